// ===== src/addr_map_pkg.sv
// Purpose: constants for the program and register address decoder
// Assumes: one clock, synchronous active-low reset
// Notes: option byte layouts and register file regions
package addr_map_pkg;
  localparam int PADDR_W = 16;
  localparam int RDATA_W = 8;
  localparam logic [15:0] VECTOR_TOP = 16'h00FF;
  localparam logic [15:0] OPT_FIRST = 16'h003C;
  localparam logic [15:0] OPT_LAST = 16'h003F;
  localparam logic [15:0] OPT_BOOT_ADDR = 16'h003E;
  localparam logic [15:0] OPT_POWER_ADDR = 16'h003F;
  localparam logic [15:0] RESET_VECTOR = 16'h0100;
  localparam logic [15:0] BOOT_BASE = 16'h0100;
  localparam logic [7:0] OPT_ERASED = 8'hFF;
  // boot option byte fields
  localparam int VEC_KEEP_BIT = 7;
  localparam int VEC_SEL_HI = 6;
  localparam int VEC_SEL_LO = 5;
  localparam int PROT_OFF_BIT = 2;
  localparam int SIZE_SEL_HI = 1;
  localparam int SIZE_SEL_LO = 0;
  // power option byte fields
  localparam int DETECT_KEEP_BIT = 7;
  localparam int FREQ_HI = 6;
  localparam int FREQ_LO = 2;
  localparam logic [4:0] FREQ_4MHZ = 5'h1E;
  localparam logic [4:0] FREQ_8MHZ = 5'h1F;
  // register file regions
  localparam logic [7:0] PRIME_LAST = 8'hBF;
  localparam logic [7:0] SET_FIRST = 8'hC0;
  localparam logic [7:0] COMMON_LAST = 8'hCF;
  localparam logic [7:0] SYS_FIRST = 8'hD0;
  localparam logic [7:0] BANK_FIRST = 8'hE0;
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hDF;
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  // physical storage: prime 192, common 16, set 2 64, sys 16, two banks 64
  localparam int RAM_DEPTH = 352;
  localparam int RAM_AW = 9;
  localparam logic [8:0] BASE_SET2 = 9'h0C0;
  localparam logic [8:0] BASE_SET1 = 9'h100;
  localparam logic [8:0] BASE_BANK1 = 9'h140;

  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_INDEXED,
    MODE_WORKING
  } reg_mode_t;

  typedef enum logic [1:0] {
    FREQ_RANGE_4,
    FREQ_RANGE_8,
    FREQ_RANGE_OTHER
  } freq_range_t;
endpackage : addr_map_pkg

// ===== src/reg_store_if.sv
// Purpose: carries one access between decoder and register storage
// Assumes: single clock
// Notes: read data is registered in the storage
interface reg_store_if;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output wr, input rdata);
  modport slave (input addr, input wdata, input wr, output rdata);
endinterface : reg_store_if

// ===== src/reg_store.sv
// Purpose: physical register file storage
// Assumes: write and registered read in one cycle
// Notes: no reset, contents undefined until written
module reg_store
  import addr_map_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // access
  reg_store_if.slave port
);
  logic [7:0] mem [RAM_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (port.wr) begin
      mem[port.addr] <= port.wdata;
    end
    port.rdata <= mem[port.addr];
  end
endmodule : reg_store

// ===== src/register_file_address_map.sv
// Purpose: program memory and register file address decoder
// Assumes: CPU core drives accesses synchronous to clk_sys
// Notes: option bytes are latched from program reads of 003EH/003FH
//
// Notes on behaviour
// - 16-bit program address decodes 64 KB flash; 8-bit register bus.
// - lowest 256 program bytes hold vectors; 03CH..03FH are option cells.
// - execution starts at 0100H unless option bytes pick another vector.
// - only 003EH and 003FH steer startup; 003CH/003DH ignored.
// - erased options 0FFH: no internal POR, detector on, 100H, no protect.
// - bit 3EH.7 one keeps 0100H; zero lets 3EH.6-5 pick vector.
// - boot sector spans 0100H to one below the selected vector.
// - 3EH.2 zero blocks erase/program of the boot region sized by 3EH.1-0.
// - 3FH.7 zero: internal POR on, detector off in stop, back on at wake.
// - 3FH.7 one: detector stays on in stop, internal POR off.
// - 3FH.6-2 code 11110 is 1-4 MHz, 11111 is 1-8 MHz.
// - E0H..FFH of set 1 banked by bank instructions; lower half not.
// - hardware reset selects bank 0.
// - page select at DFH resets to 0; all accesses go to page 0.
// - C0H..FFH reach set 2 only by indirect or indexed modes.
// - common area C0H..CFH reachable only by working register mode.
// - 192-byte prime area plus common and set 2 give 272 bytes.
// - bank 0/1 upper space and D0H..DFH hold control registers.
// - prime area 00H..BFH accepts every mode, usable right after reset.
module register_file_address_map
  import addr_map_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // program bus
  input wire logic progReq,
  input wire logic [addr_map_pkg::PADDR_W-1:0] progAddr,
  input wire logic [7:0] progData,
  input wire logic progModify,
  output logic progIsVector,
  output logic progIsOption,
  output logic progModifyOk,
  output logic progModifyBlocked,
  // startup configuration
  output logic [15:0] resetVector,
  output logic bootProtectOn,
  output logic [15:0] bootLast,
  output logic internalPowerOnReset,
  output logic lowVoltageDetectorOn,
  output addr_map_pkg::freq_range_t freqRange,
  // power state
  input wire logic stopMode,
  // bank select instructions
  input wire logic selectLowBank,
  input wire logic selectHighBank,
  // register bus
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire addr_map_pkg::reg_mode_t regMode,
  input wire logic [addr_map_pkg::RDATA_W-1:0] regWdata,
  output logic [addr_map_pkg::RDATA_W-1:0] regRdata,
  output logic regValid,
  output logic regRefused,
  output logic bankHigh,
  output logic [7:0] registerPageSelect
);
  import addr_map_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // option byte capture
  // ---------------------------------------------------------------
  // options come up erased until the core fetches the real bytes
  logic [7:0] bootOpt;
  logic [7:0] powerOpt;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bootOpt <= OPT_ERASED;
      powerOpt <= OPT_ERASED;
    end else if (progReq && !progModify) begin
      // 003CH/003DH land in neither byte
      if (progAddr == OPT_BOOT_ADDR) begin
        bootOpt <= progData;
      end
      if (progAddr == OPT_POWER_ADDR) begin
        powerOpt <= progData;
      end
    end
  end

  // ---------------------------------------------------------------
  // derived startup settings
  // ---------------------------------------------------------------
  logic [15:0] next_vector;
  logic [15:0] next_bootLast;
  logic [15:0] protLast;

  function automatic logic [15:0] vec_of(input logic [1:0] code);
    logic [15:0] v;
    v = 16'h0200;
    unique case (code)
      2'b00: v = 16'h0200;
      2'b01: v = 16'h0300;
      2'b10: v = 16'h0500;
      2'b11: v = 16'h0900;
    endcase
    return v;
  endfunction : vec_of

  always_comb begin
    if (bootOpt[VEC_KEEP_BIT]) begin
      next_vector = RESET_VECTOR;
    end else begin
      next_vector = vec_of(bootOpt[VEC_SEL_HI:VEC_SEL_LO]);
    end
    next_bootLast = next_vector - 16'h0001;
    // size code uses the same ladder: 256..2048 bytes above 0100H
    protLast = vec_of(bootOpt[SIZE_SEL_HI:SIZE_SEL_LO]) - 16'h0001;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resetVector <= RESET_VECTOR;
      bootLast <= RESET_VECTOR - 16'h0001;
      bootProtectOn <= 1'b0;
    end else begin
      resetVector <= next_vector;
      bootLast <= next_bootLast;
      bootProtectOn <= !bootOpt[PROT_OFF_BIT];
    end
  end

  // ---------------------------------------------------------------
  // power-on reset and detector control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      internalPowerOnReset <= 1'b0;
      lowVoltageDetectorOn <= 1'b1;
    end else begin
      internalPowerOnReset <= !powerOpt[DETECT_KEEP_BIT];
      // wake clears stopMode, detector comes back on by itself
      lowVoltageDetectorOn <= powerOpt[DETECT_KEEP_BIT] || !stopMode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      freqRange <= FREQ_RANGE_8;
    end else begin
      unique case (powerOpt[FREQ_HI:FREQ_LO])
        FREQ_4MHZ: freqRange <= FREQ_RANGE_4;
        FREQ_8MHZ: freqRange <= FREQ_RANGE_8;
        default: freqRange <= FREQ_RANGE_OTHER;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // program address decode
  // ---------------------------------------------------------------
  logic inProt;
  assign inProt = bootProtectOn && progAddr >= BOOT_BASE &&
                  progAddr <= protLast;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      progIsVector <= 1'b0;
      progIsOption <= 1'b0;
      progModifyOk <= 1'b0;
      progModifyBlocked <= 1'b0;
    end else begin
      // full 16-bit range is flash, nothing decodes outside
      progIsVector <= progReq && progAddr <= VECTOR_TOP;
      progIsOption <= progReq && progAddr >= OPT_FIRST &&
                      progAddr <= OPT_LAST;
      progModifyOk <= progReq && progModify && !inProt;
      progModifyBlocked <= progReq && progModify && inProt;
    end
  end

  // ---------------------------------------------------------------
  // bank and page select
  // ---------------------------------------------------------------
  logic pageSel;
  logic pageHit;
  // lower half is unbanked, bank 1 must not hide the page select
  assign pageSel = regReq && regAddr == PAGE_SEL_ADDR &&
                   (regMode == MODE_DIRECT || regMode == MODE_WORKING);
  assign pageHit = pageSel && regWrite;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bankHigh <= 1'b0;
    end else if (selectHighBank) begin
      bankHigh <= 1'b1;
    end else if (selectLowBank) begin
      bankHigh <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      registerPageSelect <= PAGE_SEL_RESET;
    end else if (pageHit) begin
      // stored for readback only, decode ignores it
      registerPageSelect <= regWdata;
    end
  end

  // ---------------------------------------------------------------
  // register address decode
  // ---------------------------------------------------------------
  reg_store_if store ();
  logic [8:0] next_phys;
  logic next_refuse;
  logic upper;

  assign upper = regAddr >= SET_FIRST;

  always_comb begin
    next_phys = {1'b0, regAddr};
    next_refuse = 1'b0;
    if (!upper) begin
      next_phys = {1'b0, regAddr};
    end else if (regMode == MODE_INDIRECT || regMode == MODE_INDEXED) begin
      // set 2 sits on top of the prime area in storage
      next_phys = BASE_SET2 + {3'b000, regAddr[5:0]};
    end else if (regAddr <= COMMON_LAST) begin
      next_phys = BASE_SET1 + {3'b000, regAddr[5:0]};
      next_refuse = regMode != MODE_WORKING;
    end else if (regAddr >= BANK_FIRST && bankHigh) begin
      next_phys = BASE_BANK1 + {4'b0000, regAddr[4:0]};
    end else begin
      // D0H..DFH and bank 0 upper half share set 1 storage
      next_phys = BASE_SET1 + {3'b000, regAddr[5:0]};
    end
  end

  assign store.addr = next_phys;
  assign store.wdata = regWdata;
  assign store.wr = regReq && regWrite && !next_refuse && !pageHit;

  reg_store u_store (
    .clk_sys(clk_sys),
    .port(store)
  );

  logic pageRead;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regValid <= 1'b0;
      regRefused <= 1'b0;
      pageRead <= 1'b0;
    end else begin
      regValid <= regReq && !regWrite && !next_refuse;
      regRefused <= regReq && next_refuse;
      pageRead <= pageSel;
    end
  end

  // read data leaves the storage register; page select muxed in
  assign regRdata = pageRead ? registerPageSelect : store.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_highSel;
    selectHighBank ##1 1'b1;
  endsequence

  sequence s_lowSel;
    selectLowBank && !selectHighBank ##1 1'b1;
  endsequence

  sequence s_fourMhzCode;
    powerOpt[FREQ_HI:FREQ_LO] == FREQ_4MHZ;
  endsequence

  AST_RESET_VEC: assert property (
    bootOpt[VEC_KEEP_BIT] |=> resetVector == RESET_VECTOR)
    else $error("reset vector not 0100H with keep bit set");
  // top code must land on the far end of the ladder
  AST_BOOT_LAST: assert property (
    !bootOpt[VEC_KEEP_BIT] && bootOpt[VEC_SEL_HI:VEC_SEL_LO] == 2'b11
    |=> bootLast == 16'h08FF)
    else $error("boot sector end mismatch");
  AST_VEC_LOW: assert property (
    !bootOpt[VEC_KEEP_BIT] && bootOpt[VEC_SEL_HI:VEC_SEL_LO] == 2'b00
    |=> resetVector == 16'h0200)
    else $error("lowest vector code not 0200H");
  AST_PROTECT: assert property (
    progReq && progModify && bootProtectOn && progAddr == BOOT_BASE
    |=> progModifyBlocked && !progModifyOk)
    else $error("boot region modify not blocked");
  AST_UNPROTECT: assert property (
    progReq && progModify && !bootProtectOn
    |=> progModifyOk && !progModifyBlocked)
    else $error("modify blocked with protection off");
  AST_DETECT_STOP: assert property (
    !powerOpt[DETECT_KEEP_BIT] && stopMode |=> !lowVoltageDetectorOn)
    else $error("detector on in stop");
  AST_POR_ON: assert property (
    !powerOpt[DETECT_KEEP_BIT] |=> internalPowerOnReset)
    else $error("internal reset off with keep bit clear");
  AST_DETECT_KEEP: assert property (
    powerOpt[DETECT_KEEP_BIT] |=> lowVoltageDetectorOn &&
    !internalPowerOnReset)
    else $error("detector or internal reset wrong");
  AST_FREQ_4: assert property (
    s_fourMhzCode |=> freqRange == FREQ_RANGE_4)
    else $error("frequency range not 1-4 MHz");
  AST_BANK_HIGH: assert property (
    s_highSel |-> bankHigh)
    else $error("bank 1 not selected");
  AST_BANK_LOW: assert property (
    s_lowSel |-> !bankHigh)
    else $error("bank 0 not selected");
  AST_PAGE_WRITE: assert property (
    pageHit |=> registerPageSelect == $past(regWdata))
    else $error("page select write lost");
  AST_SET2: assert property (
    regReq && (regMode == MODE_INDIRECT || regMode == MODE_INDEXED)
    |=> !regRefused)
    else $error("set 2 access refused");
  AST_COMMON: assert property (
    regReq && regMode == MODE_DIRECT && regAddr >= SET_FIRST &&
    regAddr <= COMMON_LAST |=> regRefused)
    else $error("common area reached without working mode");
  // a refused write must not reach the storage either
  AST_COMMON_WR: assert property (
    regReq && regMode == MODE_DIRECT && regAddr >= SET_FIRST &&
    regAddr <= COMMON_LAST |-> !store.wr)
    else $error("direct write reached the common area");
  AST_PRIME: assert property (
    regReq && !regWrite && regAddr <= PRIME_LAST
    |=> regValid && !regRefused)
    else $error("prime area read not answered");
  AST_VECTOR: assert property (
    progReq && progAddr == 16'h0100 |=> !progIsVector)
    else $error("0100H flagged as vector");
  AST_OPTION: assert property (
    progReq && progAddr >= OPT_FIRST && progAddr <= OPT_LAST
    |=> progIsOption && progIsVector)
    else $error("option cell not flagged");
endmodule : register_file_address_map

// ===== verification/cpu_core_model.sv
// Purpose: core model issuing program and register bus accesses
// Assumes: request launched 1 ns after an edge, taken at the next edge
// Notes: released address/data lines carry the inverted last value
module cpu_core_model
  import addr_map_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // program bus
  output logic progReq,
  output logic [15:0] progAddr,
  output logic [7:0] progData,
  output logic progModify,
  // register bus
  output logic regReq,
  output logic regWrite,
  output logic [7:0] regAddr,
  output addr_map_pkg::reg_mode_t regMode,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRefused,
  // bank instructions
  output logic selectLowBank,
  output logic selectHighBank
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {progReq, progModify, regReq, regWrite} = 4'h0;
    {selectLowBank, selectHighBank} = 2'b00;
    progAddr = 16'h0000;
    progData = 8'h00;
    regAddr = 8'h00;
    regMode = MODE_DIRECT;
    regWdata = 8'h00;
  end
  task automatic prog(input logic [15:0] a, input logic [7:0] d,
                      input logic m);
    @(posedge clk_sys);
    #1;
    progReq = 1'b1;
    progAddr = a;
    progData = d;
    progModify = m;
    @(posedge clk_sys);
    #1;
    progReq = 1'b0;
    progAddr = ~a;
    progData = ~d;
  endtask : prog
  // answer is sampled once the taking edge has landed
  task automatic rg(input logic w, input logic [7:0] a,
                    input reg_mode_t md, input logic [7:0] d,
                    output logic [7:0] rd, output logic rf);
    @(posedge clk_sys);
    #1;
    regReq = 1'b1;
    regWrite = w;
    regAddr = a;
    regMode = md;
    regWdata = d;
    @(posedge clk_sys);
    #1;
    rd = regRdata;
    rf = regRefused;
    regReq = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask : rg
  task automatic bank(input logic hi);
    @(posedge clk_sys);
    #1;
    selectHighBank = hi;
    selectLowBank = !hi;
    @(posedge clk_sys);
    #1;
    {selectLowBank, selectHighBank} = 2'b00;
  endtask : bank
endmodule : cpu_core_model

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the address map decoder
// Assumes: one-cycle registered answers from the decoder
// Notes: option bytes are steered by program reads of 003EH/003FH
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import addr_map_pkg::*;
  logic clk_sys, rst_n, stopMode;
  logic progReq, progModify, regReq, regWrite;
  logic selectLowBank, selectHighBank;
  logic [15:0] progAddr, resetVector, bootLast;
  logic [7:0] progData, regAddr, regWdata, regRdata, registerPageSelect;
  reg_mode_t regMode;
  freq_range_t freqRange;
  logic progIsVector, progIsOption, progModifyOk, progModifyBlocked;
  logic bootProtectOn, internalPowerOnReset, lowVoltageDetectorOn;
  logic regValid, regRefused, bankHigh;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [15:0] vecTab [4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
  register_file_address_map uut (.clk_sys, .rst_n, .progReq, .progAddr,
    .progData, .progModify, .progIsVector, .progIsOption, .progModifyOk,
    .progModifyBlocked, .resetVector, .bootProtectOn, .bootLast,
    .internalPowerOnReset, .lowVoltageDetectorOn, .freqRange, .stopMode,
    .selectLowBank, .selectHighBank, .regReq, .regWrite, .regAddr,
    .regMode, .regWdata, .regRdata, .regValid, .regRefused, .bankHigh,
    .registerPageSelect);
  cpu_core_model core (.clk_sys, .progReq, .progAddr, .progData,
    .progModify, .regReq, .regWrite, .regAddr, .regMode, .regWdata,
    .regRdata, .regRefused, .selectLowBank, .selectHighBank);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
  endtask : do_reset
  task automatic modify(input logic [15:0] a, input logic blk);
    core.prog(a, 8'h00, 1'b1);
    chk(progModifyBlocked, blk);
    chk(progModifyOk, !blk);
  endtask : modify
  task automatic racc(input logic w, input logic [7:0] a,
                      input reg_mode_t m, input logic [7:0] d,
                      input logic rfx);
    logic [7:0] rd;
    logic rf;
    core.rg(w, a, m, d, rd, rf);
    chk(rf, rfx);
    chk(regValid, !w && !rfx);
    if (!w && !rfx) begin
      chk(rd, d);
    end
  endtask : racc
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(resetVector, 16'h0100);
    chk(bootLast, 16'h00FF);
    chk(bootProtectOn, 1'b0);
    chk(internalPowerOnReset, 1'b0);
    chk(lowVoltageDetectorOn, 1'b1);
    chk(bankHigh, 1'b0);
    chk(registerPageSelect, 8'h00);
    chk(freqRange, FREQ_RANGE_8);
  endtask : t_reset
  task automatic t_flags;
    logic [15:0] at [6] = '{16'h003B, 16'h003C, 16'h003F, 16'h0040,
                            16'h00FF, 16'h0100};
    foreach (at[i]) begin
      core.prog(at[i], 8'hFF, 1'b0);
      chk(progIsVector, at[i] <= 16'h00FF);
      chk(progIsOption, at[i] >= 16'h003C && at[i] <= 16'h003F);
    end
  endtask : t_flags
  task automatic t_boot;
    for (int c = 0; c < 4; c++) begin
      core.prog(16'h003E, {1'b0, c[1:0], 5'h1F}, 1'b0);
      settle;
      chk(resetVector, vecTab[c]);
      chk(bootLast, vecTab[c] - 16'h0001);
      chk(bootProtectOn, 1'b0);
    end
    core.prog(16'h003C, 8'h00, 1'b0);
    core.prog(16'h003D, 8'h00, 1'b0);
    settle;
    chk(resetVector, 16'h0900);
    core.prog(16'h003E, 8'h9F, 1'b0);
    settle;
    chk(resetVector, 16'h0100);
  endtask : t_boot
  task automatic t_protect;
    for (int c = 0; c < 4; c++) begin
      // vector kept at 0100H so only the size code moves the boundary
      core.prog(16'h003E, {1'b1, 2'b11, 3'b110, c[1:0]}, 1'b0);
      settle;
      chk(bootProtectOn, 1'b1);
      modify(vecTab[c] - 16'h0001, 1'b1);
      modify(vecTab[c], 1'b0);
      modify(16'h0100, 1'b1);
      modify(16'h00FF, 1'b0);
    end
    core.prog(16'h003E, 8'hFF, 1'b0);
    settle;
    modify(16'h0100, 1'b0);
  endtask : t_protect
  task automatic t_power;
    core.prog(16'h003F, 8'h78, 1'b0);
    settle;
    chk(internalPowerOnReset, 1'b1);
    chk(freqRange, FREQ_RANGE_4);
    stopMode = 1'b1;
    settle;
    chk(lowVoltageDetectorOn, 1'b0);
    stopMode = 1'b0;
    settle;
    chk(lowVoltageDetectorOn, 1'b1);
    core.prog(16'h003F, 8'hFC, 1'b0);
    stopMode = 1'b1;
    settle;
    chk(internalPowerOnReset, 1'b0);
    chk(freqRange, FREQ_RANGE_8);
    chk(lowVoltageDetectorOn, 1'b1);
    core.prog(16'h003F, 8'h80, 1'b0);
    settle;
    chk(freqRange, FREQ_RANGE_OTHER);
    chk(internalPowerOnReset, 1'b0);
    stopMode = 1'b0;
  endtask : t_power
  task automatic t_regs;
    racc(1'b1, 8'h10, MODE_DIRECT, 8'h5A, 1'b0);
    racc(1'b0, 8'h10, MODE_INDIRECT, 8'h5A, 1'b0);
    racc(1'b1, 8'hC5, MODE_DIRECT, 8'h99, 1'b1);
    racc(1'b1, 8'hC5, MODE_WORKING, 8'h33, 1'b0);
    racc(1'b1, 8'hC5, MODE_INDIRECT, 8'h44, 1'b0);
    racc(1'b0, 8'hC5, MODE_INDEXED, 8'h44, 1'b0);
    racc(1'b0, 8'hC5, MODE_WORKING, 8'h33, 1'b0);
    racc(1'b1, 8'hD5, MODE_DIRECT, 8'h66, 1'b0);
    racc(1'b1, 8'hD5, MODE_INDIRECT, 8'h77, 1'b0);
    racc(1'b0, 8'hD5, MODE_DIRECT, 8'h66, 1'b0);
    core.bank(1'b1);
    chk(bankHigh, 1'b1);
    racc(1'b1, 8'hE0, MODE_DIRECT, 8'h11, 1'b0);
    core.bank(1'b0);
    chk(bankHigh, 1'b0);
    racc(1'b1, 8'hE0, MODE_DIRECT, 8'h22, 1'b0);
    core.bank(1'b1);
    racc(1'b0, 8'hE0, MODE_DIRECT, 8'h11, 1'b0);
    racc(1'b0, 8'hD5, MODE_DIRECT, 8'h66, 1'b0);
    racc(1'b0, 8'hDF, MODE_DIRECT, 8'h00, 1'b0);
    racc(1'b1, 8'hDF, MODE_DIRECT, 8'h30, 1'b0);
    chk(registerPageSelect, 8'h30);
    racc(1'b0, 8'hDF, MODE_WORKING, 8'h30, 1'b0);
    racc(1'b0, 8'h10, MODE_DIRECT, 8'h5A, 1'b0);
    do_reset;
    chk(bankHigh, 1'b0);
    chk(registerPageSelect, 8'h00);
    racc(1'b0, 8'h10, MODE_DIRECT, 8'h5A, 1'b0);
  endtask : t_regs
  initial begin
    rst_n = 1'b0;
    stopMode = 1'b0;
    do_reset;
    t_reset;
    t_flags;
    t_boot;
    t_protect;
    t_power;
    t_regs;
    close_out;
  end
  // hang guard, far above the length of the sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out;
  end
endmodule : tb_top
